//--- src/crf_pkg.sv
package crf_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int WORD_W   = 16;
    localparam int BYTE_W   = 8;
    localparam int PHYS_W   = 20;
    localparam int SEG_SHIFT = 4;
    localparam int NUM_GEN  = 8;
    localparam int NUM_SEG  = 4;
    localparam int NUM_ARCH = 14;

    // ------------------------------------------------------------------
    // Word register encodings (3-bit operand field)
    // ------------------------------------------------------------------
    localparam logic [2:0] R_ACCUM = 3'h0;
    localparam logic [2:0] R_COUNT = 3'h1;
    localparam logic [2:0] R_PDATA = 3'h2;
    localparam logic [2:0] R_BASE  = 3'h3;
    localparam logic [2:0] R_STACK = 3'h4;
    localparam logic [2:0] R_FRAME = 3'h5;
    localparam logic [2:0] R_SRCIX = 3'h6;
    localparam logic [2:0] R_DSTIX = 3'h7;

    // Byte encodings: codes 0..3 low halves, 4..7 high halves of 0..3
    localparam logic [1:0] BYTE_IDX_MSK = 2'h3;

    // Segment encodings
    localparam logic [1:0] S_EXTRA = 2'h0;
    localparam logic [1:0] S_CODE  = 2'h1;
    localparam logic [1:0] S_STACK = 2'h2;
    localparam logic [1:0] S_DATA  = 2'h3;

    // ------------------------------------------------------------------
    // Flag word layout
    // ------------------------------------------------------------------
    localparam int FL_CARRY = 0;
    localparam int FL_PAR   = 2;
    localparam int FL_AUX   = 4;
    localparam int FL_ZERO  = 6;
    localparam int FL_SIGN  = 7;
    localparam int FL_TRACE = 8;
    localparam int FL_INTEN = 9;
    localparam int FL_DIR   = 10;
    localparam int FL_OVF   = 11;
    localparam logic [15:0] FLAGS_IMPL_MSK = 16'h0fd5;
    localparam logic [15:0] FLAGS_RST      = 16'h0000;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] WORD_RST     = 16'h0000;
    localparam logic [15:0] CODE_SEG_RST = 16'hffff;
    localparam logic [15:0] IP_RST       = 16'h0000;

    // Address-generator base/index choices
    typedef enum logic [2:0] {
        EA_NONE  = 3'h0,
        EA_BASE  = 3'h1,
        EA_FRAME = 3'h2,
        EA_SRCIX = 3'h3,
        EA_DSTIX = 3'h4
    } crf_ea_sel_t;

    // Stack step per word
    localparam logic [15:0] STACK_STEP = 16'h0002;

endpackage : crf_pkg

//--- src/crf_gen_bank.sv
`timescale 1ns/1ps
module crf_gen_bank
    import crf_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wr_en,
    input  wire logic              wr_byte,
    input  wire logic [2:0]        wr_sel,
    input  wire logic [15:0]       wr_data,
    input  wire logic              sp_wr_en,
    input  wire logic [15:0]       sp_wr_data,
    input  wire logic              si_wr_en,
    input  wire logic [15:0]       si_wr_data,
    input  wire logic              di_wr_en,
    input  wire logic [15:0]       di_wr_data,
    output logic [NUM_GEN*16-1:0]  regs_flat
);
    logic [15:0] gen_r   [NUM_GEN];
    logic [15:0] gen_nxt [NUM_GEN];
    logic [1:0]  bidx;

    // ------------------------------------------------------------------
    // Next-value logic
    // ------------------------------------------------------------------
    // Byte codes reach four words
    always_comb begin
        bidx = wr_sel[1:0] & BYTE_IDX_MSK;
        for (int i = 0; i < NUM_GEN; i++) begin
            gen_nxt[i] = gen_r[i];
        end
        if (wr_en && wr_byte) begin
            if (wr_sel[2]) begin
                gen_nxt[bidx][15:8] = wr_data[7:0];
            end else begin
                gen_nxt[bidx][7:0] = wr_data[7:0];
            end
        end else if (wr_en) begin
            gen_nxt[wr_sel] = wr_data;
        end
        // Stack and string pointer updates
        if (sp_wr_en) begin
            gen_nxt[R_STACK] = sp_wr_data;
        end
        if (si_wr_en) begin
            gen_nxt[R_SRCIX] = si_wr_data;
        end
        if (di_wr_en) begin
            gen_nxt[R_DSTIX] = di_wr_data;
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_GEN; i++) begin
                gen_r[i] <= WORD_RST;
            end
        end else begin
            for (int i = 0; i < NUM_GEN; i++) begin
                gen_r[i] <= gen_nxt[i];
            end
        end
    end

    // Flat view for the parent
    always_comb begin
        for (int i = 0; i < NUM_GEN; i++) begin
            regs_flat[i*16 +: 16] = gen_r[i];
        end
    end
endmodule : crf_gen_bank

//--- src/crf_addr_gen.sv
`timescale 1ns/1ps
module crf_addr_gen
    import crf_pkg::*;
(
    input  wire logic [15:0] seg_base,
    input  wire logic [15:0] offset,
    output logic      [19:0] phys
);
    // ------------------------------------------------------------------
    // Segment plus offset
    // ------------------------------------------------------------------
    // Shifted base plus offset
    always_comb begin
        phys = {seg_base, {SEG_SHIFT{1'b0}}} + {{SEG_SHIFT{1'b0}}, offset};
    end
endmodule : crf_addr_gen

//--- src/crf_core_regs.sv
`timescale 1ns/1ps
module crf_core_regs
    import crf_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              RESETN,
    // General register write port
    input  wire logic              GEN_WR_EN,
    input  wire logic              GEN_WR_BYTE,
    input  wire logic [2:0]        GEN_WR_SEL,
    input  wire logic [15:0]       GEN_WR_DATA,
    // General register read ports
    input  wire logic              RDA_BYTE,
    input  wire logic [2:0]        RDA_SEL,
    input  wire logic              RDB_BYTE,
    input  wire logic [2:0]        RDB_SEL,
    output logic      [15:0]       RDA_DATA,
    output logic      [15:0]       RDB_DATA,
    // Segment bases
    input  wire logic              SEG_WR_EN,
    input  wire logic [1:0]        SEG_WR_SEL,
    input  wire logic [15:0]       SEG_WR_DATA,
    // Instruction offset
    input  wire logic              IP_LOAD,
    input  wire logic [15:0]       IP_LOAD_DATA,
    input  wire logic              IP_ADV,
    input  wire logic [2:0]        IP_ADV_LEN,
    // Flag word
    input  wire logic              FLAGS_WR_EN,
    input  wire logic [15:0]       FLAGS_WR_DATA,
    input  wire logic [15:0]       FLAGS_WR_MASK,
    // Stack engine
    input  wire logic              STK_PUSH,
    input  wire logic              STK_POP,
    // String engine
    input  wire logic              STR_SRC_STEP,
    input  wire logic              STR_DST_STEP,
    input  wire logic              STR_WORD,
    // Memory operand address request
    input  wire crf_ea_sel_t       EA_BASE_SEL,
    input  wire crf_ea_sel_t       EA_INDEX_SEL,
    input  wire logic [15:0]       EA_DISP,
    input  wire logic              EA_SEG_OVR,
    input  wire logic [1:0]        EA_SEG_OVR_SEL,
    // Results
    output logic      [19:0]       MEM_PHYS_ADDR,
    output logic      [19:0]       STACK_PHYS_ADDR,
    output logic      [19:0]       FETCH_PHYS_ADDR,
    output logic      [19:0]       SRC_PHYS_ADDR,
    output logic      [19:0]       DST_PHYS_ADDR,
    output logic      [15:0]       NEXT_INSTR_OFFSET,
    output logic      [15:0]       FLAGS_WORD,
    output logic                   TRACE_EN,
    output logic                   INT_EN,
    output logic                   DIR_DOWN
);

    // ------------------------------------------------------------------
    // Storage: 8 general + 4 segment + offset + flags = 14 registers
    // ------------------------------------------------------------------
    // only these fourteen live here; peripherals are memory
    logic [NUM_GEN*16-1:0] gen_flat;
    logic [15:0]           seg_r   [NUM_SEG];
    logic [15:0]           seg_nxt [NUM_SEG];
    logic [15:0]           ip_r;
    logic [15:0]           ip_nxt;
    logic [15:0]           flags_r;
    logic [15:0]           flags_nxt;

    // Pointer next values
    logic [15:0]           sp_nxt_v;
    logic [15:0]           si_nxt_v;
    logic [15:0]           di_nxt_v;
    logic [15:0]           str_step;

    // Address inputs
    logic [15:0]           ea_off;
    logic [15:0]           mem_seg;
    logic [19:0]           mem_pa;
    logic [19:0]           stk_pa;
    logic [19:0]           fet_pa;
    logic [19:0]           src_pa;
    logic [19:0]           dst_pa;

    // Output registers
    logic [15:0]           rda_r;
    logic [15:0]           rdb_r;
    logic [19:0]           mem_pa_r;
    logic [19:0]           stk_pa_r;
    logic [19:0]           fet_pa_r;
    logic [19:0]           src_pa_r;
    logic [19:0]           dst_pa_r;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Word or byte read
    function automatic logic [15:0] gen_read(input logic [NUM_GEN*16-1:0] bank,
                                             input logic byte_mode,
                                             input logic [2:0] sel);
        logic [15:0] w;
        w = bank[sel*16 +: 16];
        if (byte_mode) begin
            w = bank[{1'b0, sel[1:0]}*16 +: 16];
            gen_read = sel[2] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
        end else begin
            gen_read = w;
        end
    endfunction : gen_read

    // Only four registers may be base or index
    function automatic logic [15:0] ea_term(input logic [NUM_GEN*16-1:0] bank,
                                            input crf_ea_sel_t sel);
        case (sel)
            EA_BASE:  ea_term = bank[R_BASE*16 +: 16];
            EA_FRAME: ea_term = bank[R_FRAME*16 +: 16];
            EA_SRCIX: ea_term = bank[R_SRCIX*16 +: 16];
            EA_DSTIX: ea_term = bank[R_DSTIX*16 +: 16];
            default:  ea_term = '0;
        endcase
    endfunction : ea_term

    // ------------------------------------------------------------------
    // Implicit pointer arithmetic
    // ------------------------------------------------------------------
    // Push down, pop up; strings follow direction
    always_comb begin
        sp_nxt_v = gen_flat[R_STACK*16 +: 16];
        if (STK_PUSH) begin
            sp_nxt_v = gen_flat[R_STACK*16 +: 16] - STACK_STEP;
        end else if (STK_POP) begin
            sp_nxt_v = gen_flat[R_STACK*16 +: 16] + STACK_STEP;
        end
        str_step = STR_WORD ? STACK_STEP : 16'h0001;
        if (flags_r[FL_DIR]) begin
            si_nxt_v = gen_flat[R_SRCIX*16 +: 16] - str_step;
            di_nxt_v = gen_flat[R_DSTIX*16 +: 16] - str_step;
        end else begin
            si_nxt_v = gen_flat[R_SRCIX*16 +: 16] + str_step;
            di_nxt_v = gen_flat[R_DSTIX*16 +: 16] + str_step;
        end
    end

    // General register bank
    crf_gen_bank u_gen (
        .clk        (REF_CLK),
        .rst_n      (RESETN),
        .wr_en      (GEN_WR_EN),
        .wr_byte    (GEN_WR_BYTE),
        .wr_sel     (GEN_WR_SEL),
        .wr_data    (GEN_WR_DATA),
        .sp_wr_en   (STK_PUSH | STK_POP),
        .sp_wr_data (sp_nxt_v),
        .si_wr_en   (STR_SRC_STEP),
        .si_wr_data (si_nxt_v),
        .di_wr_en   (STR_DST_STEP),
        .di_wr_data (di_nxt_v),
        .regs_flat  (gen_flat)
    );

    // ------------------------------------------------------------------
    // Segment, offset and flag next values
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_SEG; i++) begin
            seg_nxt[i] = seg_r[i];
        end
        if (SEG_WR_EN) begin
            seg_nxt[SEG_WR_SEL] = SEG_WR_DATA;
        end
        ip_nxt = ip_r;
        if (IP_LOAD) begin
            ip_nxt = IP_LOAD_DATA;
        end else if (IP_ADV) begin
            ip_nxt = ip_r + {13'h0000, IP_ADV_LEN};
        end
        flags_nxt = flags_r;
        if (FLAGS_WR_EN) begin
            flags_nxt = ((flags_r & ~FLAGS_WR_MASK) | (FLAGS_WR_DATA & FLAGS_WR_MASK))
                        & FLAGS_IMPL_MSK;
        end
    end

    // Register stage for segment, offset and flags
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            seg_r[S_EXTRA] <= WORD_RST;
            seg_r[S_CODE]  <= CODE_SEG_RST;
            seg_r[S_STACK] <= WORD_RST;
            seg_r[S_DATA]  <= WORD_RST;
            ip_r           <= IP_RST;
            flags_r        <= FLAGS_RST;
        end else begin
            for (int i = 0; i < NUM_SEG; i++) begin
                seg_r[i] <= seg_nxt[i];
            end
            ip_r    <= ip_nxt;
            flags_r <= flags_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Address generation
    // ------------------------------------------------------------------
    // Frame-based references use stack segment unless overridden
    always_comb begin
        ea_off = ea_term(gen_flat, EA_BASE_SEL) + ea_term(gen_flat, EA_INDEX_SEL)
                 + EA_DISP;
        if (EA_SEG_OVR) begin
            mem_seg = seg_r[EA_SEG_OVR_SEL];
        end else if (EA_BASE_SEL == EA_FRAME) begin
            mem_seg = seg_r[S_STACK];
        end else begin
            mem_seg = seg_r[S_DATA];
        end
    end

    crf_addr_gen u_mem (
        .seg_base (mem_seg),
        .offset   (ea_off),
        .phys     (mem_pa)
    );

    // Stack ignores any override
    crf_addr_gen u_stk (
        .seg_base (seg_r[S_STACK]),
        .offset   (gen_flat[R_STACK*16 +: 16]),
        .phys     (stk_pa)
    );

    crf_addr_gen u_fet (
        .seg_base (seg_r[S_CODE]),
        .offset   (ip_r),
        .phys     (fet_pa)
    );

    crf_addr_gen u_src (
        .seg_base (EA_SEG_OVR ? seg_r[EA_SEG_OVR_SEL] : seg_r[S_DATA]),
        .offset   (gen_flat[R_SRCIX*16 +: 16]),
        .phys     (src_pa)
    );

    crf_addr_gen u_dst (
        .seg_base (seg_r[S_EXTRA]),
        .offset   (gen_flat[R_DSTIX*16 +: 16]),
        .phys     (dst_pa)
    );

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rda_r    <= WORD_RST;
            rdb_r    <= WORD_RST;
            mem_pa_r <= '0;
            stk_pa_r <= '0;
            fet_pa_r <= '0;
            src_pa_r <= '0;
            dst_pa_r <= '0;
        end else begin
            rda_r    <= gen_read(gen_flat, RDA_BYTE, RDA_SEL);
            rdb_r    <= gen_read(gen_flat, RDB_BYTE, RDB_SEL);
            mem_pa_r <= mem_pa;
            stk_pa_r <= stk_pa;
            fet_pa_r <= fet_pa;
            src_pa_r <= src_pa;
            dst_pa_r <= dst_pa;
        end
    end

    // Ports from flops
    assign RDA_DATA          = rda_r;
    assign RDB_DATA          = rdb_r;
    assign MEM_PHYS_ADDR     = mem_pa_r;
    assign STACK_PHYS_ADDR   = stk_pa_r;
    assign FETCH_PHYS_ADDR   = fet_pa_r;
    assign SRC_PHYS_ADDR     = src_pa_r;
    assign DST_PHYS_ADDR     = dst_pa_r;
    assign NEXT_INSTR_OFFSET = ip_r;
    assign FLAGS_WORD        = flags_r;
    assign TRACE_EN          = flags_r[FL_TRACE];
    assign INT_EN            = flags_r[FL_INTEN];
    assign DIR_DOWN          = flags_r[FL_DIR];

endmodule : crf_core_regs

//--- verif/crf_core_regs_asserts.sv
`timescale 1ns/1ps
module crf_core_regs_asserts
    import crf_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        RESETN,
    input wire logic        GEN_WR_EN,
    input wire logic        GEN_WR_BYTE,
    input wire logic [2:0]  GEN_WR_SEL,
    input wire logic [15:0] GEN_WR_DATA,
    input wire logic        RDA_BYTE,
    input wire logic [2:0]  RDA_SEL,
    input wire logic [15:0] RDA_DATA,
    input wire logic        SEG_WR_EN,
    input wire logic        IP_LOAD,
    input wire logic [15:0] IP_LOAD_DATA,
    input wire logic        IP_ADV,
    input wire logic [2:0]  IP_ADV_LEN,
    input wire logic        FLAGS_WR_EN,
    input wire logic [15:0] FLAGS_WR_DATA,
    input wire logic [15:0] FLAGS_WR_MASK,
    input wire logic        STK_PUSH,
    input wire logic        STK_POP,
    input wire logic [19:0] STACK_PHYS_ADDR,
    input wire logic [15:0] NEXT_INSTR_OFFSET,
    input wire logic [15:0] FLAGS_WORD,
    input wire logic        TRACE_EN,
    input wire logic        INT_EN,
    input wire logic        DIR_DOWN
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    // Push, then a quiet cycle
    sequence push_quiet_s;
        STK_PUSH && !SEG_WR_EN && !GEN_WR_EN ##1 !STK_PUSH && !STK_POP && !SEG_WR_EN && !GEN_WR_EN;
    endsequence

    flags_upd_a: assert property (FLAGS_WR_EN |=> FLAGS_WORD ==
        ((($past(FLAGS_WORD) & ~$past(FLAGS_WR_MASK)) | ($past(FLAGS_WR_DATA)
        & $past(FLAGS_WR_MASK))) & FLAGS_IMPL_MSK)) else $error("flag word update wrong");
    ctrl_bits_a: assert property ({DIR_DOWN, INT_EN, TRACE_EN} == FLAGS_WORD[10:8])
        else $error("control flag outputs differ from flag word");
    ip_load_a: assert property (IP_LOAD |=> NEXT_INSTR_OFFSET == $past(IP_LOAD_DATA))
        else $error("offset load wrong");
    ip_adv_a: assert property (IP_ADV && !IP_LOAD |=> NEXT_INSTR_OFFSET ==
        $past(NEXT_INSTR_OFFSET) + 16'($past(IP_ADV_LEN))) else $error("offset advance wrong");
    ip_hold_a: assert property (!IP_LOAD && !IP_ADV |=> $stable(NEXT_INSTR_OFFSET))
        else $error("offset moved without request");
    stack_step_a: assert property (push_quiet_s |=> STACK_PHYS_ADDR[3:0] ==
        4'($past(STACK_PHYS_ADDR[3:0]) - 4'h2)) else $error("push step wrong");
    rda_word_a: assert property (GEN_WR_EN && !GEN_WR_BYTE && GEN_WR_SEL == R_ACCUM
        ##1 !GEN_WR_EN && !RDA_BYTE && RDA_SEL == R_ACCUM |=> RDA_DATA == $past(GEN_WR_DATA, 2))
        else $error("word read after write wrong");
    byte_hi_a: assert property (GEN_WR_EN && GEN_WR_BYTE && GEN_WR_SEL == 3'h4
        ##1 !GEN_WR_EN && !RDA_BYTE && RDA_SEL == R_ACCUM
        |=> RDA_DATA[15:8] == $past(GEN_WR_DATA[7:0], 2)) else $error("high byte write wrong");
    byte_zext_a: assert property (RDA_BYTE |=> RDA_DATA[15:8] == 8'h00)
        else $error("byte read not zero extended");

    // Main scenarios
    push_c: cover property (STK_PUSH);
    flags_c: cover property (FLAGS_WR_EN && FLAGS_WR_MASK == 16'hffff);
    byte_c: cover property (GEN_WR_EN && GEN_WR_BYTE);
endmodule : crf_core_regs_asserts

//--- verif/crf_dp_model.sv
`timescale 1ns/1ps
module crf_dp_model (
    input  wire logic clk,
    output logic      stk_push,
    output logic      stk_pop
);
    // Idle at start
    initial begin
        stk_push = 1'b0;
        stk_pop  = 1'b0;
    end

    // One push or pop, then an idle gap
    task automatic stack_op(input logic push, input int gap);
        @(negedge clk);
        stk_push = push;
        stk_pop  = !push;
        @(negedge clk);
        stk_push = 1'b0;
        stk_pop  = 1'b0;
        repeat (gap) @(negedge clk);
    endtask : stack_op
endmodule : crf_dp_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import crf_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic        clk, resetn, gen_wr_en, gen_wr_byte, rda_byte, rdb_byte, seg_wr_en;
    logic        ip_load, ip_adv, flags_wr_en, src_step, dst_step, str_word, ea_ovr;
    logic        stk_push, stk_pop, trace_en, int_en, dir_down;
    logic [2:0]  gen_wr_sel, rda_sel, rdb_sel, ip_adv_len;
    logic [1:0]  seg_wr_sel, ea_ovr_sel;
    logic [15:0] gen_wr_data, seg_wr_data, ip_load_data, flags_data, flags_mask, ea_disp;
    logic [15:0] rda_data, rdb_data, next_off, flags_word;
    logic [19:0] mem_pa, stack_pa, fetch_pa, src_pa, dst_pa;
    crf_ea_sel_t ea_base_sel, ea_index_sel;
    int          error_cnt, n_checks;

    crf_core_regs i_crf_core_regs (.REF_CLK(clk), .RESETN(resetn), .GEN_WR_EN(gen_wr_en),
        .GEN_WR_BYTE(gen_wr_byte), .GEN_WR_SEL(gen_wr_sel), .GEN_WR_DATA(gen_wr_data),
        .RDA_BYTE(rda_byte), .RDA_SEL(rda_sel), .RDB_BYTE(rdb_byte), .RDB_SEL(rdb_sel),
        .RDA_DATA(rda_data), .RDB_DATA(rdb_data), .SEG_WR_EN(seg_wr_en),
        .SEG_WR_SEL(seg_wr_sel), .SEG_WR_DATA(seg_wr_data), .IP_LOAD(ip_load),
        .IP_LOAD_DATA(ip_load_data), .IP_ADV(ip_adv), .IP_ADV_LEN(ip_adv_len),
        .FLAGS_WR_EN(flags_wr_en), .FLAGS_WR_DATA(flags_data), .FLAGS_WR_MASK(flags_mask),
        .STK_PUSH(stk_push), .STK_POP(stk_pop), .STR_SRC_STEP(src_step),
        .STR_DST_STEP(dst_step), .STR_WORD(str_word), .EA_BASE_SEL(ea_base_sel),
        .EA_INDEX_SEL(ea_index_sel), .EA_DISP(ea_disp), .EA_SEG_OVR(ea_ovr),
        .EA_SEG_OVR_SEL(ea_ovr_sel), .MEM_PHYS_ADDR(mem_pa), .STACK_PHYS_ADDR(stack_pa),
        .FETCH_PHYS_ADDR(fetch_pa), .SRC_PHYS_ADDR(src_pa), .DST_PHYS_ADDR(dst_pa),
        .NEXT_INSTR_OFFSET(next_off), .FLAGS_WORD(flags_word), .TRACE_EN(trace_en),
        .INT_EN(int_en), .DIR_DOWN(dir_down));
    crf_dp_model i_crf_dp_model (.clk(clk), .stk_push(stk_push), .stk_pop(stk_pop));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic gen_wr(input logic b, input logic [2:0] s, input logic [15:0] d);
        {gen_wr_en, gen_wr_byte, gen_wr_sel, gen_wr_data} = {1'b1, b, s, d};
        tick(1);
        gen_wr_en = 1'b0;
    endtask : gen_wr
    task automatic seg_wr(input logic [1:0] s, input logic [15:0] d);
        {seg_wr_en, seg_wr_sel, seg_wr_data} = {1'b1, s, d};
        tick(1);
        seg_wr_en = 1'b0;
    endtask : seg_wr
    task automatic flags_wr(input logic [15:0] d, input logic [15:0] m);
        {flags_wr_en, flags_data, flags_mask} = {1'b1, d, m};
        tick(1);
        flags_wr_en = 1'b0;
    endtask : flags_wr
    // Both read ports, data one edge later
    task automatic rd_chk(input logic b, input logic [2:0] s, input logic [15:0] exp);
        {rda_byte, rda_sel, rdb_byte, rdb_sel} = {b, s, b, s};
        tick(1);
        chk("RDA_DATA", 20'(rda_data), 20'(exp));
        chk("RDB_DATA", 20'(rdb_data), 20'(exp));
    endtask : rd_chk
    task automatic str_step(input logic w);
        {src_step, dst_step, str_word} = {1'b1, 1'b1, w};
        tick(1);
        {src_step, dst_step} = 2'b00;
        tick(1);
    endtask : str_step

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk("FETCH", fetch_pa, 20'hffff0);
        chk("NEXT_OFF", 20'(next_off), 20'h0);
        chk("FLAGS", 20'(flags_word), 20'h0);
    endtask : t_reset
    task automatic t_words;
        for (int i = 0; i < 8; i++) begin
            gen_wr(1'b0, 3'(i), 16'h1111 * 16'(i + 1));
            rd_chk(1'b0, 3'(i), 16'h1111 * 16'(i + 1));
        end
        rd_chk(1'b0, R_ACCUM, 16'h1111);
    endtask : t_words
    task automatic t_bytes;
        for (int i = 0; i < 4; i++) begin
            gen_wr(1'b0, 3'(i), 16'ha5a5);
            gen_wr(1'b1, 3'(i + 4), 16'hff3c);
            rd_chk(1'b0, 3'(i), 16'h3ca5);
            gen_wr(1'b1, 3'(i), 16'h0077);
            rd_chk(1'b0, 3'(i), 16'h3c77);
            rd_chk(1'b1, 3'(i + 4), 16'h003c);
        end
    endtask : t_bytes
    task automatic t_flags;
        flags_wr(16'hffff, 16'hffff);
        chk("FLAGS", 20'(flags_word), 20'h00fd5);
        chk("CTRL", 20'({dir_down, int_en, trace_en}), 20'h7);
        flags_wr(16'h0000, 16'h0401);
        chk("FLAGS", 20'(flags_word), 20'h00bd4);
        chk("CTRL", 20'({dir_down, int_en, trace_en}), 20'h3);
    endtask : t_flags
    task automatic t_ip;
        {ip_load, ip_load_data} = {1'b1, 16'h1234};
        tick(1);
        ip_load = 1'b0;
        chk("NEXT_OFF", 20'(next_off), 20'h01234);
        {ip_adv, ip_adv_len} = {1'b1, 3'h7};
        tick(1);
        ip_adv = 1'b0;
        chk("NEXT_OFF", 20'(next_off), 20'h0123b);
        {ip_load, ip_adv, ip_load_data} = {2'b11, 16'h0022};
        tick(1);
        {ip_load, ip_adv} = 2'b00;
        chk("NEXT_OFF", 20'(next_off), 20'h00022);
        seg_wr(S_CODE, 16'h12a4);
        tick(1);
        chk("FETCH", fetch_pa, 20'h12a62);
    endtask : t_ip
    task automatic t_mem;
        seg_wr(S_DATA, 16'h1000);
        seg_wr(S_STACK, 16'h2000);
        seg_wr(S_EXTRA, 16'h3000);
        gen_wr(1'b0, R_BASE, 16'h0010);
        gen_wr(1'b0, R_SRCIX, 16'h0004);
        gen_wr(1'b0, R_FRAME, 16'h0020);
        {ea_base_sel, ea_index_sel, ea_disp} = {EA_BASE, EA_SRCIX, 16'h0100};
        tick(1);
        chk("MEM_PA", mem_pa, 20'h10114);
        ea_base_sel = EA_FRAME;
        tick(1);
        chk("MEM_PA", mem_pa, 20'h20124);
        {ea_ovr, ea_ovr_sel} = {1'b1, S_EXTRA};
        tick(1);
        chk("MEM_PA", mem_pa, 20'h30124);
    endtask : t_mem
    task automatic t_stack;
        gen_wr(1'b0, R_STACK, 16'h0100);
        tick(1);
        chk("STACK_PA", stack_pa, 20'h20100);
        i_crf_dp_model.stack_op(1'b1, 0);
        tick(1);
        chk("STACK_PA", stack_pa, 20'h200fe);
        i_crf_dp_model.stack_op(1'b0, 3);
        chk("STACK_PA", stack_pa, 20'h20100);
        ea_ovr = 1'b0;
    endtask : t_stack
    task automatic t_string;
        gen_wr(1'b0, R_DSTIX, 16'h0008);
        tick(1);
        chk("SRC_PA", src_pa, 20'h10004);
        chk("DST_PA", dst_pa, 20'h30008);
        str_step(1'b1);
        chk("SRC_PA", src_pa, 20'h10006);
        chk("DST_PA", dst_pa, 20'h3000a);
        flags_wr(16'h0400, 16'h0400);
        chk("DIR_DOWN", 20'(dir_down), 20'h1);
        str_step(1'b0);
        chk("SRC_PA", src_pa, 20'h10005);
        chk("DST_PA", dst_pa, 20'h30009);
    endtask : t_string

    task automatic final_report;
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("ERROR watchdog expected finish seen hang");
        final_report();
    end

    // Main sequence
    initial begin
        {resetn, gen_wr_en, gen_wr_byte, rda_byte, rdb_byte, seg_wr_en, ip_load, ip_adv} = '0;
        {flags_wr_en, src_step, dst_step, str_word, ea_ovr, gen_wr_sel, rda_sel} = '0;
        {rdb_sel, ip_adv_len, seg_wr_sel, ea_ovr_sel, gen_wr_data, seg_wr_data} = '0;
        {ip_load_data, flags_data, flags_mask, ea_disp} = '0;
        {ea_base_sel, ea_index_sel} = {EA_NONE, EA_NONE};
        {error_cnt, n_checks} = '0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        tick(1);
        t_reset();
        t_words();
        t_bytes();
        t_flags();
        t_ip();
        t_mem();
        t_stack();
        t_string();
        final_report();
    end
endmodule : tb_top

bind crf_core_regs crf_core_regs_asserts i_crf_core_regs_asserts (.REF_CLK(REF_CLK),
    .RESETN(RESETN), .GEN_WR_EN(GEN_WR_EN), .GEN_WR_BYTE(GEN_WR_BYTE),
    .GEN_WR_SEL(GEN_WR_SEL), .GEN_WR_DATA(GEN_WR_DATA), .RDA_BYTE(RDA_BYTE),
    .RDA_SEL(RDA_SEL), .RDA_DATA(RDA_DATA), .SEG_WR_EN(SEG_WR_EN), .IP_LOAD(IP_LOAD),
    .IP_LOAD_DATA(IP_LOAD_DATA), .IP_ADV(IP_ADV), .IP_ADV_LEN(IP_ADV_LEN),
    .FLAGS_WR_EN(FLAGS_WR_EN), .FLAGS_WR_DATA(FLAGS_WR_DATA), .FLAGS_WR_MASK(FLAGS_WR_MASK),
    .STK_PUSH(STK_PUSH), .STK_POP(STK_POP), .STACK_PHYS_ADDR(STACK_PHYS_ADDR),
    .NEXT_INSTR_OFFSET(NEXT_INSTR_OFFSET), .FLAGS_WORD(FLAGS_WORD), .TRACE_EN(TRACE_EN),
    .INT_EN(INT_EN), .DIR_DOWN(DIR_DOWN));
